// File: design/ddc_map.vh
// Register map, field positions and reset values of the comparator control
// Behaviour
// - First threshold is 10 bits: bits 9..2 in its high register, bits 1..0 in the low register's two low bits, rest read zero, all reset to zero.
// - Second threshold is 10 bits split the same way over its own high and low registers, unused bits read zero, reset zero.
// - With the second event select set, either second-threshold flag interrupts; with it clear only the falling flag does.
// - The second falling flag sets when the second threshold drops below the negative input and stays until software clears it.
// - The second rising flag sets when the second threshold rises above the negative input and stays until software clears it.
// - Second-threshold requests on o_cmp_irq pass only while the second interrupt enable is one; o_irq gates their status bits with the mask instead.
// - The second result bit is read-only, resets to zero, reads one while the comparator is on and the second threshold is above the negative input.
// - The first event select works the same way for the first-threshold flags.
// - A two-bit field selects the ADC and comparator toggle mode, passed out undecoded.
// - Writing the comparator enable to zero disables the comparator function.
// - The comparator enable bit lives in the first control register: one enables, zero disables.
// - A three-bit field selects the negative input; the all-ones code is reserved and never taken.
// - The first rising and falling flags set on the first threshold going above or below the negative input; software clears each.
// - The first result bit is read-only and reads one while the comparator is on and the first threshold is above the negative input.
`ifndef DDC_MAP_VH
`define DDC_MAP_VH

`define DDC_ADDR_CTRL_ONE 8'h35
`define DDC_ADDR_THR1_HI 8'h36
`define DDC_ADDR_THR1_LO 8'h37
`define DDC_ADDR_CTRL_TWO 8'h38
`define DDC_ADDR_THR2_HI 8'h39
`define DDC_ADDR_THR2_LO 8'h3a
`define DDC_ADDR_IRQ_STAT 8'h3b
`define DDC_ADDR_IRQ_MASK 8'h3c

// Control one fields
`define DDC_C1_ON 7
`define DDC_C1_RES 6
`define DDC_C1_IE 5
`define DDC_C1_RISE 4
`define DDC_C1_FALL 3
`define DDC_C1_NSEL_HI 2
`define DDC_C1_NSEL_LO 0

// Control two fields
`define DDC_C2_SEL1 7
`define DDC_C2_RES 6
`define DDC_C2_IE 5
`define DDC_C2_RISE 4
`define DDC_C2_FALL 3
`define DDC_C2_SEL2 2
`define DDC_C2_TOG_HI 1
`define DDC_C2_TOG_LO 0

// Status and mask layout
`define DDC_ST_RISE1 0
`define DDC_ST_FALL1 1
`define DDC_ST_RISE2 2
`define DDC_ST_FALL2 3

`define DDC_NSEL_RSVD 3'h7
`define DDC_RST_BYTE 8'h00
`define DDC_RST_CODE 10'h000
`define DDC_RST_NIB 4'h0

`endif

// File: design/ddc_sync.v
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module ddc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // ddc_sync

// File: design/ddc_flag.v
// Edge flags, result bit and request for one threshold comparison
`timescale 1ns/1ns
module ddc_flag (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_enable,
  input wire i_level,
  input wire i_clr_rise,
  input wire i_clr_fall,
  input wire i_irq_en,
  input wire i_any_edge,
  output wire o_result,
  output wire o_rise,
  output wire o_fall,
  output wire o_rise_evt,
  output wire o_fall_evt,
  output wire o_req
);
  reg prev_q;
  reg result_q;
  reg rise_q;
  reg fall_q;

  // Edges only count while the comparator runs
  assign o_rise_evt = i_enable & i_level & ~prev_q;
  assign o_fall_evt = i_enable & ~i_level & prev_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
      result_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      prev_q <= i_level;
      result_q <= i_enable & i_level;
      // Set wins over a clear in the same cycle
      rise_q <= o_rise_evt | (rise_q & ~i_clr_rise);
      fall_q <= o_fall_evt | (fall_q & ~i_clr_fall);
    end
  end

  assign o_result = result_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;
  assign o_req = i_irq_en & (fall_q | (i_any_edge & rise_q));
endmodule // ddc_flag

// File: design/ddc_ctrl.v
// Dual threshold comparator control: registers, flags and interrupts
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "ddc_map.vh"
module ddc_ctrl (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [7:0] o_rdata,
  input wire i_cmp1_raw,
  input wire i_cmp2_raw,
  output wire o_comparator_on,
  output wire [2:0] o_negative_input_select,
  output wire [9:0] o_first_threshold_dac,
  output wire [9:0] o_second_threshold_dac,
  output wire [1:0] o_toggle_mode_select,
  output wire o_cmp_irq,
  output wire o_irq
);
  // Reset release
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // Register state
  reg on_q;
  reg ie1_q;
  reg [2:0] nsel_q;
  reg sel1_q;
  reg ie2_q;
  reg sel2_q;
  reg [1:0] tog_q;
  reg [7:0] thr1_hi_q;
  reg [1:0] thr1_lo_q;
  reg [7:0] thr2_hi_q;
  reg [1:0] thr2_lo_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  // Write decode
  wire wr_c1;
  wire wr_c2;
  wire wr_t1h;
  wire wr_t1l;
  wire wr_t2h;
  wire wr_t2l;
  wire wr_stat;
  wire wr_mask;

  assign wr_c1 = i_wr & (i_addr == `DDC_ADDR_CTRL_ONE);
  assign wr_c2 = i_wr & (i_addr == `DDC_ADDR_CTRL_TWO);
  assign wr_t1h = i_wr & (i_addr == `DDC_ADDR_THR1_HI);
  assign wr_t1l = i_wr & (i_addr == `DDC_ADDR_THR1_LO);
  assign wr_t2h = i_wr & (i_addr == `DDC_ADDR_THR2_HI);
  assign wr_t2l = i_wr & (i_addr == `DDC_ADDR_THR2_LO);
  assign wr_stat = i_wr & (i_addr == `DDC_ADDR_IRQ_STAT);
  assign wr_mask = i_wr & (i_addr == `DDC_ADDR_IRQ_MASK);

  // Comparator outputs arrive from the analog side
  wire [1:0] cmp_sync;

  ddc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_async({i_cmp2_raw, i_cmp1_raw}),
    .o_sync(cmp_sync)
  );

  // Flags are cleared by writing zero to them
  wire clr_r1;
  wire clr_f1;
  wire clr_r2;
  wire clr_f2;

  assign clr_r1 = wr_c1 & ~i_wdata[`DDC_C1_RISE];
  assign clr_f1 = wr_c1 & ~i_wdata[`DDC_C1_FALL];
  assign clr_r2 = wr_c2 & ~i_wdata[`DDC_C2_RISE];
  assign clr_f2 = wr_c2 & ~i_wdata[`DDC_C2_FALL];

  wire res1;
  wire rise1;
  wire fall1;
  wire rise1_evt;
  wire fall1_evt;
  wire req1;
  wire res2;
  wire rise2;
  wire fall2;
  wire rise2_evt;
  wire fall2_evt;
  wire req2;

  ddc_flag u_first (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_enable(on_q),
    .i_level(cmp_sync[0]),
    .i_clr_rise(clr_r1),
    .i_clr_fall(clr_f1),
    .i_irq_en(ie1_q),
    .i_any_edge(sel1_q),
    .o_result(res1),
    .o_rise(rise1),
    .o_fall(fall1),
    .o_rise_evt(rise1_evt),
    .o_fall_evt(fall1_evt),
    .o_req(req1)
  );

  ddc_flag u_second (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_enable(on_q),
    .i_level(cmp_sync[1]),
    .i_clr_rise(clr_r2),
    .i_clr_fall(clr_f2),
    .i_irq_en(ie2_q),
    .i_any_edge(sel2_q),
    .o_result(res2),
    .o_rise(rise2),
    .o_fall(fall2),
    .o_rise_evt(rise2_evt),
    .o_fall_evt(fall2_evt),
    .o_req(req2)
  );

  // Control registers
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q <= 1'b0;
      ie1_q <= 1'b0;
      nsel_q <= 3'h0;
      sel1_q <= 1'b0;
      ie2_q <= 1'b0;
      sel2_q <= 1'b0;
      tog_q <= 2'h0;
    end else begin
      if (wr_c1) begin
        on_q <= i_wdata[`DDC_C1_ON];
        ie1_q <= i_wdata[`DDC_C1_IE];
        if (i_wdata[`DDC_C1_NSEL_HI:`DDC_C1_NSEL_LO] != `DDC_NSEL_RSVD) begin
          nsel_q <= i_wdata[`DDC_C1_NSEL_HI:`DDC_C1_NSEL_LO];
        end
      end
      if (wr_c2) begin
        sel1_q <= i_wdata[`DDC_C2_SEL1];
        ie2_q <= i_wdata[`DDC_C2_IE];
        sel2_q <= i_wdata[`DDC_C2_SEL2];
        tog_q <= i_wdata[`DDC_C2_TOG_HI:`DDC_C2_TOG_LO];
      end
    end
  end

  // Threshold registers
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr1_hi_q <= `DDC_RST_BYTE;
      thr1_lo_q <= 2'h0;
      thr2_hi_q <= `DDC_RST_BYTE;
      thr2_lo_q <= 2'h0;
    end else begin
      if (wr_t1h) begin
        thr1_hi_q <= i_wdata;
      end
      if (wr_t1l) begin
        thr1_lo_q <= i_wdata[1:0];
      end
      if (wr_t2h) begin
        thr2_hi_q <= i_wdata;
      end
      if (wr_t2l) begin
        thr2_lo_q <= i_wdata[1:0];
      end
    end
  end

  // Sticky event status, write one to clear, set wins
  wire [3:0] evt;

  assign evt = {fall2_evt, rise2_evt, fall1_evt, rise1_evt};

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= `DDC_RST_NIB;
      mask_q <= `DDC_RST_NIB;
    end else begin
      stat_q <= evt | (stat_q & ~({4{wr_stat}} & i_wdata[3:0]));
      if (wr_mask) begin
        mask_q <= i_wdata[3:0];
      end
    end
  end

  // Read mux; result bits come from the flag units only
  always @* begin
    rdata_d = 8'h00;
    case (i_addr)
      `DDC_ADDR_CTRL_ONE: begin
        rdata_d = {on_q, res1, ie1_q, rise1, fall1, nsel_q};
      end
      `DDC_ADDR_CTRL_TWO: begin
        rdata_d = {sel1_q, res2, ie2_q, rise2, fall2, sel2_q, tog_q};
      end
      `DDC_ADDR_THR1_HI: begin
        rdata_d = thr1_hi_q;
      end
      `DDC_ADDR_THR1_LO: begin
        rdata_d = {6'h00, thr1_lo_q};
      end
      `DDC_ADDR_THR2_HI: begin
        rdata_d = thr2_hi_q;
      end
      `DDC_ADDR_THR2_LO: begin
        rdata_d = {6'h00, thr2_lo_q};
      end
      `DDC_ADDR_IRQ_STAT: begin
        rdata_d = {4'h0, stat_q};
      end
      `DDC_ADDR_IRQ_MASK: begin
        rdata_d = {4'h0, mask_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_comparator_on = on_q;
  assign o_negative_input_select = nsel_q;
  assign o_first_threshold_dac = {thr1_hi_q, thr1_lo_q};
  assign o_second_threshold_dac = {thr2_hi_q, thr2_lo_q};
  assign o_toggle_mode_select = tog_q;
  assign o_cmp_irq = req1 | req2;
  assign o_irq = |(stat_q & mask_q);
endmodule // ddc_ctrl

// File: verif/ddc_cmp_model.sv
// Behavioural analog comparator for the two threshold settings
`timescale 1ns/1ns
module ddc_cmp_model (
  input wire [9:0] i_first_threshold_dac,
  input wire [9:0] i_second_threshold_dac,
  input wire [9:0] i_level,
  output wire o_cmp1,
  output wire o_cmp2
);
  // High while a threshold sits above the negative input, enabled or not
  assign o_cmp1 = (i_first_threshold_dac > i_level);
  assign o_cmp2 = (i_second_threshold_dac > i_level);
endmodule // ddc_cmp_model

// File: verif/ddc_ctrl_properties.sv
// Port assertions for the comparator control
`timescale 1ns/1ns
module ddc_ctrl_props (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_comparator_on,
  input wire [2:0] o_negative_input_select,
  input wire [9:0] o_first_threshold_dac,
  input wire [9:0] o_second_threshold_dac,
  input wire [1:0] o_toggle_mode_select,
  input wire o_cmp_irq,
  input wire o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  a_thr1_high: assert property (i_wr && i_addr == 8'h36 |=>
    o_first_threshold_dac[9:2] == $past(i_wdata)) else $error("thr1 high");
  a_thr2_low: assert property (i_wr && i_addr == 8'h3a |=>
    o_second_threshold_dac[1:0] == $past(i_wdata[1:0])) else $error("thr2");
  a_on_write: assert property (i_wr && i_addr == 8'h35 |=>
    o_comparator_on == $past(i_wdata[7])) else $error("enable bit");
  a_nsel_write: assert property (i_wr && i_addr == 8'h35 &&
    i_wdata[2:0] != 3'h7 |=> o_negative_input_select == $past(i_wdata[2:0]))
    else $error("input select");
  a_nsel_rsvd: assert property (i_wr && i_addr == 8'h35 &&
    i_wdata[2:0] == 3'h7 |=> $stable(o_negative_input_select))
    else $error("reserved select taken");
  a_tog_write: assert property (i_wr && i_addr == 8'h38 |=>
    o_toggle_mode_select == $past(i_wdata[1:0])) else $error("toggle mode");
  a_req_sticky: assert property (o_cmp_irq && !(i_wr &&
    (i_addr == 8'h35 || i_addr == 8'h38)) |=> o_cmp_irq)
    else $error("request dropped");
  a_irq_sticky: assert property (o_irq && !(i_wr &&
    (i_addr == 8'h3b || i_addr == 8'h3c)) |=> o_irq) else $error("irq dropped");
  a_low_unused: assert property (i_rd &&
    (i_addr == 8'h37 || i_addr == 8'h3a) |=> o_rdata[7:2] == 6'h00)
    else $error("low register upper bits set");
  a_res_off: assert property (i_rd && !o_comparator_on &&
    !$past(o_comparator_on) && (i_addr == 8'h35 || i_addr == 8'h38)
    |=> !o_rdata[6]) else $error("result bit set while off");
endmodule // ddc_ctrl_props

bind ddc_ctrl ddc_ctrl_props u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_comparator_on(o_comparator_on),
  .o_negative_input_select(o_negative_input_select),
  .o_first_threshold_dac(o_first_threshold_dac),
  .o_second_threshold_dac(o_second_threshold_dac),
  .o_toggle_mode_select(o_toggle_mode_select), .o_cmp_irq(o_cmp_irq),
  .o_irq(o_irq));

// File: verif/ddc_ctrl_tb.sv
// Self-checking bench for the comparator control
`timescale 1ns/1ns
module ddc_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [9:0] lvl = 10'h3ff;
  wire [7:0] rdata;
  wire c1, c2, on, cirq, irq;
  wire [2:0] nsel;
  wire [9:0] d1, d2;
  wire [1:0] tog;
  int error_cnt = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  ddc_ctrl u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_cmp1_raw(c1), .i_cmp2_raw(c2), .o_comparator_on(on),
    .o_negative_input_select(nsel), .o_first_threshold_dac(d1),
    .o_second_threshold_dac(d2), .o_toggle_mode_select(tog),
    .o_cmp_irq(cirq), .o_irq(irq));
  ddc_cmp_model u_cmp (.i_first_threshold_dac(d1), .i_second_threshold_dac(d2), .i_level(lvl),
    .o_cmp1(c1), .o_cmp2(c2));
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic set_lvl(logic [9:0] v);
    @(posedge clk);
    lvl <= v;
  endtask
  task automatic wait_req;
    for (int i = 0; i < 10 && cirq !== 1'b1; i++) @(posedge clk);
    #1;
    if (cirq !== 1'b1) begin
      error_cnt++;
      $display("Error cmp_irq expected 1 seen %b", cirq);
      tally_and_finish;
    end
  endtask
  task automatic t_regs;
    for (int a = 8'h35; a <= 8'h3c; a++) begin
      rd_reg(a[7:0], 8'h00);
    end
    rd_reg(8'h40, 8'h00);
    wr_reg(8'h36, 8'hab);
    wr_reg(8'h37, 8'hff);
    wr_reg(8'h39, 8'h5c);
    wr_reg(8'h3a, 8'hfe);
    rd_reg(8'h36, 8'hab);
    rd_reg(8'h37, 8'h03);
    rd_reg(8'h3a, 8'h02);
    rd_reg(8'h39, 8'h5c);
    chk("first_threshold_dac", 10'h2af, d1);
    chk("second_threshold_dac", 10'h172, d2);
    $display("t_regs done");
  endtask
  task automatic t_ctrl;
    wr_reg(8'h35, 8'h83);
    wr_reg(8'h35, 8'h87);
    chk("nsel", 10'h3, nsel);
    chk("on", 10'h1, on);
    wr_reg(8'h35, 8'hc3);
    rd_reg(8'h35, 8'h83);
    for (int t = 0; t < 4; t++) begin
      wr_reg(8'h38, t[7:0]);
      chk("tog", t[9:0], tog);
    end
    $display("t_ctrl done");
  endtask
  task automatic t_first;
    wr_reg(8'h35, 8'ha3);
    set_lvl(10'h000);
    repeat (6) @(posedge clk);
    #1;
    chk("cmp_irq", 10'h0, cirq);
    rd_reg(8'h35, 8'hf3);
    set_lvl(10'h3ff);
    wait_req;
    rd_reg(8'h35, 8'hbb);
    rd_reg(8'h38, 8'h1b);
    rd_reg(8'h3b, 8'h0f);
    chk("irq", 10'h0, irq);
    wr_reg(8'h3c, 8'h0f);
    chk("irq", 10'h1, irq);
    wr_reg(8'h3b, 8'h0f);
    chk("irq", 10'h0, irq);
    rd_reg(8'h3b, 8'h00);
    wr_reg(8'h35, 8'ha3);
    chk("cmp_irq", 10'h0, cirq);
    wr_reg(8'h38, 8'h00);
    $display("t_first done");
  endtask
  task automatic t_second;
    wr_reg(8'h38, 8'h24);
    set_lvl(10'h000);
    wait_req;
    rd_reg(8'h38, 8'h74);
    wr_reg(8'h38, 8'h14);
    chk("cmp_irq", 10'h0, cirq);
    wr_reg(8'h38, 8'h30);
    chk("cmp_irq", 10'h0, cirq);
    wr_reg(8'h38, 8'h34);
    chk("cmp_irq", 10'h1, cirq);
    $display("t_second done");
  endtask
  task automatic t_select;
    wr_reg(8'h35, 8'h83);
    wr_reg(8'h38, 8'h20);
    chk("cmp_irq", 10'h0, cirq);
    set_lvl(10'h3ff);
    wait_req;
    rd_reg(8'h38, 8'h28);
    wr_reg(8'h35, 8'ha3);
    wr_reg(8'h38, 8'h80);
    chk("cmp_irq", 10'h0, cirq);
    set_lvl(10'h000);
    wait_req;
    wr_reg(8'h38, 8'h34);
    $display("t_select done");
  endtask
  task automatic t_off;
    wr_reg(8'h3b, 8'h0f);
    wr_reg(8'h35, 8'h03);
    set_lvl(10'h3ff);
    repeat (6) @(posedge clk);
    rd_reg(8'h35, 8'h03);
    rd_reg(8'h38, 8'h34);
    set_lvl(10'h000);
    repeat (6) @(posedge clk);
    rd_reg(8'h35, 8'h03);
    rd_reg(8'h38, 8'h34);
    rd_reg(8'h3b, 8'h00);
    chk("irq", 10'h0, irq);
    $display("t_off done");
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_ctrl;
    t_first;
    t_second;
    t_select;
    t_off;
    tally_and_finish;
  end
endmodule // ddc_ctrl_tb
